/* File: logic/mac_dma_status_flag_latches.sv */
`timescale 1ns/1ps
module mac_dma_status_flag_latches (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// bus error events
	input wire logic parity_error,
	input wire logic master_abort,
	input wire logic target_abort,
	// timer and receive events
	input wire logic gp_timer_timeout,
	input wire logic rx_watchdog_timeout,
	input wire logic rx_state_stopped,
	input wire logic rx_desc_not_owned,
	input wire logic rx_frame_recognized,
	input wire logic rx_frame_complete,
	// transmit events
	input wire logic tx_fifo_empty_in_frame,
	input wire logic tx_jabber_timeout,
	// control towards the engines
	output logic bus_access_enable,
	output logic rx_suspended,
	output logic tx_suspended,
	output logic tx_stopped,
	output logic tx_desc_status_wr,
	output logic [31:0] tx_descriptor_status_word,
	// interrupt
	output logic irq
);
	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	function automatic logic is_status(input logic [11:0] a);
		is_status = (a == flag_bank_pkg::AUX_STATUS_ADDR) ||
			(a == flag_bank_pkg::PRIMARY_STATUS_ADDR);
	endfunction : is_status

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = is_status(a) || (a == flag_bank_pkg::IRQ_MASK_ADDR) ||
			(a == flag_bank_pkg::CTRL_ADDR);
	endfunction : is_mapped

	wire logic setup_phase = psel && !penable;
	wire logic wr_access = psel && penable && pwrite;
	wire logic wr_status = wr_access && is_status(paddr);
	wire logic wr_mask = wr_access && (paddr == flag_bank_pkg::IRQ_MASK_ADDR);
	wire logic wr_ctrl = wr_access && (paddr == flag_bank_pkg::CTRL_ADDR);
	wire logic soft_rst = wr_ctrl && pwdata[flag_bank_pkg::CTRL_SOFT_RESET_BIT];
	wire logic rx_poll = wr_ctrl && pwdata[flag_bank_pkg::CTRL_RX_POLL_BIT];
	wire logic tx_poll = wr_ctrl && pwdata[flag_bank_pkg::CTRL_TX_POLL_BIT];
	wire logic rst_any = srst || soft_rst;

	// zero wait states; unmapped addresses answer with an error
	assign pready = psel && penable;
	assign pslverr = psel && penable && !is_mapped(paddr);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0] irq_mask;
	logic [2:0] bus_err_code;
	logic rx_stopped_d;
	flag_bank_pkg::rx_state_t rx_state;
	flag_bank_pkg::rx_state_t next_rx_state;
	flag_bank_pkg::tx_state_t tx_state;
	flag_bank_pkg::tx_state_t next_tx_state;
	wire logic [14:0] flags;
	logic [14:0] flag_events;

	// event vector in flag layout
	wire logic bus_fault = parity_error || master_abort || target_abort;
	wire logic rx_stop_entry = rx_state_stopped && !rx_stopped_d;
	assign flag_events = {
		1'b0,
		bus_fault,
		1'b0,
		gp_timer_timeout,
		1'b0,
		rx_watchdog_timeout,
		rx_stop_entry,
		rx_desc_not_owned,
		rx_frame_complete,
		tx_fifo_empty_in_frame,
		1'b0,
		tx_jabber_timeout,
		3'h0
	};

	// ------------------------------------------------------------
	// sticky flag bank
	// ------------------------------------------------------------
	// one latch per implemented position, reserved ones tied low
	for (genvar i = 0; i <= flag_bank_pkg::MIRROR_HI; i++) begin : g_flag
		if (flag_bank_pkg::FLAG_IMPL[i]) begin : g_impl
			sticky_flag u_flag (
				.clk(clk),
				.rst(rst_any),
				.set(flag_events[i]),
				.clr(wr_status && pwdata[i]),
				.q(flags[i])
			);
		end else begin : g_res
			assign flags[i] = 1'b0;
		end
	end

	// status word as seen from the auxiliary address; the primary address adds the bus error code
	wire logic [31:0] status_word = {16'h0000, 1'b0, flags};
	wire logic [31:0] primary_word = status_word | {6'h00, bus_err_code, 23'h000000};
	wire logic [31:0] read_mux =
		(paddr == flag_bank_pkg::AUX_STATUS_ADDR) ? status_word :
		(paddr == flag_bank_pkg::PRIMARY_STATUS_ADDR) ? primary_word :
		(paddr == flag_bank_pkg::IRQ_MASK_ADDR) ? irq_mask : 32'h0000_0000;

	// read data captured in the setup cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= flag_bank_pkg::STATUS_RESET;
		end else if (setup_phase) begin
			prdata <= read_mux;
		end
	end

	// mask register, only hardware reset clears it
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_mask <= flag_bank_pkg::MASK_RESET;
		end else if (wr_mask) begin
			irq_mask <= pwdata;
		end
	end

	// level interrupt from unmasked flags
	always_ff @(posedge clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_word & irq_mask);
		end
	end

	// ------------------------------------------------------------
	// bus fault handling
	// ------------------------------------------------------------
	// error cause kept for the primary status; access cut until soft reset
	always_ff @(posedge clk) begin
		if (rst_any) begin
			bus_err_code <= 3'h0;
			bus_access_enable <= 1'b1;
		end else begin
			bus_err_code <= bus_err_code | {target_abort, master_abort, parity_error};
			if (bus_fault) begin
				bus_access_enable <= 1'b0;
			end
		end
	end

	// receive stop edge detect
	always_ff @(posedge clk) begin
		if (rst_any) begin
			rx_stopped_d <= 1'b0;
		end else begin
			rx_stopped_d <= rx_state_stopped;
		end
	end

	// ------------------------------------------------------------
	// receive process suspend
	// ------------------------------------------------------------
	always_comb begin
		next_rx_state = rx_state;
		case (rx_state)
			flag_bank_pkg::RX_RUN: begin
				if (rx_desc_not_owned) begin
					next_rx_state = flag_bank_pkg::RX_SUSPENDED;
				end
			end
			flag_bank_pkg::RX_SUSPENDED: begin
				if (rx_poll || rx_frame_recognized) begin
					next_rx_state = flag_bank_pkg::RX_RUN;
				end
			end
			default: begin
				next_rx_state = flag_bank_pkg::RX_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst_any) begin
			rx_state <= flag_bank_pkg::RX_RUN;
		end else begin
			rx_state <= next_rx_state;
		end
	end

	assign rx_suspended = (rx_state == flag_bank_pkg::RX_SUSPENDED);

	// ------------------------------------------------------------
	// transmit process suspend and stop
	// ------------------------------------------------------------
	always_comb begin
		next_tx_state = tx_state;
		case (tx_state)
			flag_bank_pkg::TX_RUN: begin
				if (tx_jabber_timeout) begin
					next_tx_state = flag_bank_pkg::TX_STOPPED;
				end else if (tx_fifo_empty_in_frame) begin
					next_tx_state = flag_bank_pkg::TX_SUSPENDED;
				end
			end
			flag_bank_pkg::TX_SUSPENDED: begin
				if (tx_jabber_timeout) begin
					next_tx_state = flag_bank_pkg::TX_STOPPED;
				end else if (tx_poll) begin
					next_tx_state = flag_bank_pkg::TX_RUN;
				end
			end
			flag_bank_pkg::TX_STOPPED: begin
				if (tx_poll) begin
					next_tx_state = flag_bank_pkg::TX_RUN;
				end
			end
			default: begin
				next_tx_state = flag_bank_pkg::TX_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst_any) begin
			tx_state <= flag_bank_pkg::TX_RUN;
		end else begin
			tx_state <= next_tx_state;
		end
	end

	assign tx_suspended = (tx_state == flag_bank_pkg::TX_SUSPENDED);
	assign tx_stopped = (tx_state == flag_bank_pkg::TX_STOPPED);

	// descriptor status bits written back on underrun or jabber
	wire logic [31:0] desc_bits =
		({31'h0, tx_fifo_empty_in_frame} << flag_bank_pkg::DESC_UNDERRUN_BIT) |
		({31'h0, tx_jabber_timeout} << flag_bank_pkg::DESC_JABBER_BIT);

	always_ff @(posedge clk) begin
		if (rst_any) begin
			tx_desc_status_wr <= 1'b0;
			tx_descriptor_status_word <= 32'h0000_0000;
		end else begin
			tx_desc_status_wr <= tx_fifo_empty_in_frame || tx_jabber_timeout;
			if (tx_fifo_empty_in_frame || tx_jabber_timeout) begin
				tx_descriptor_status_word <= desc_bits;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_fatal_latch;
		@(posedge clk) disable iff (srst)
		(bus_fault && !soft_rst) |=> flags[flag_bank_pkg::FATAL_BIT];
	endproperty
	a_fatal_latch: assert property (p_fatal_latch) else $error("fatal flag missed");

	property p_bus_off;
		@(posedge clk) disable iff (srst)
		(bus_fault && !soft_rst) ##1 !soft_rst |-> !bus_access_enable ##1 !bus_access_enable;
	endproperty
	a_bus_off: assert property (p_bus_off) else $error("bus access after fault");

	property p_bus_recover;
		@(posedge clk) disable iff (srst)
		(!bus_access_enable && !soft_rst) |=> !bus_access_enable;
	endproperty
	a_bus_recover: assert property (p_bus_recover) else $error("bus back without reset");

	property p_soft_reset;
		@(posedge clk) disable iff (srst)
		soft_rst |=> bus_access_enable && (flags == 15'h0000);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset ineffective");

	property p_write_zero;
		@(posedge clk) disable iff (srst)
		(wr_status && !soft_rst && (pwdata[14:0] == 15'h0000)) |=>
			(flags & $past(flags)) == $past(flags);
	endproperty
	a_write_zero: assert property (p_write_zero) else $error("zero write cleared a flag");

	property p_clear_one;
		@(posedge clk) disable iff (srst)
		(wr_status && pwdata[flag_bank_pkg::RX_DONE_BIT] && !rx_frame_complete)
			|=> !flags[flag_bank_pkg::RX_DONE_BIT];
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("write one did not clear");

	property p_gp_timer;
		@(posedge clk) disable iff (srst)
		(gp_timer_timeout && !soft_rst) |=> flags[flag_bank_pkg::GP_TIMER_BIT];
	endproperty
	a_gp_timer: assert property (p_gp_timer) else $error("timer flag missed");

	property p_rx_watchdog;
		@(posedge clk) disable iff (srst)
		(rx_watchdog_timeout && !soft_rst) |=> flags[flag_bank_pkg::RX_WATCHDOG_BIT];
	endproperty
	a_rx_watchdog: assert property (p_rx_watchdog) else $error("watchdog flag missed");

	property p_rx_halt;
		@(posedge clk) disable iff (srst || soft_rst)
		$rose(rx_state_stopped) |=> flags[flag_bank_pkg::RX_HALTED_BIT];
	endproperty
	a_rx_halt: assert property (p_rx_halt) else $error("halt flag missed");

	property p_rx_starve;
		@(posedge clk) disable iff (srst)
		(rx_desc_not_owned && !soft_rst &&
			!(rx_suspended && (rx_poll || rx_frame_recognized))) |=>
			rx_suspended && flags[flag_bank_pkg::RX_STARVED_BIT];
	endproperty
	a_rx_starve: assert property (p_rx_starve) else $error("starvation not handled");

	property p_rx_resume;
		@(posedge clk) disable iff (srst)
		(rx_suspended && (rx_poll || rx_frame_recognized)) |=> !rx_suspended;
	endproperty
	a_rx_resume: assert property (p_rx_resume) else $error("receive did not resume");

	property p_rx_done;
		@(posedge clk) disable iff (srst)
		(rx_frame_complete && !soft_rst) |=> flags[flag_bank_pkg::RX_DONE_BIT];
	endproperty
	a_rx_done: assert property (p_rx_done) else $error("done flag missed");

	property p_underrun;
		@(posedge clk) disable iff (srst)
		(tx_fifo_empty_in_frame && !tx_jabber_timeout && !soft_rst && !tx_stopped &&
			!(tx_suspended && tx_poll)) |=>
			flags[flag_bank_pkg::TX_UNDERRUN_BIT] && tx_suspended && tx_desc_status_wr &&
			tx_descriptor_status_word[flag_bank_pkg::DESC_UNDERRUN_BIT];
	endproperty
	a_underrun: assert property (p_underrun) else $error("underrun not handled");

	property p_jabber;
		@(posedge clk) disable iff (srst)
		(tx_jabber_timeout && !soft_rst && !(tx_stopped && tx_poll)) |=>
			flags[flag_bank_pkg::TX_JABBER_BIT] &&
			tx_stopped && tx_descriptor_status_word[flag_bank_pkg::DESC_JABBER_BIT];
	endproperty
	a_jabber: assert property (p_jabber) else $error("jabber not handled");

	property p_mirror;
		@(posedge clk) disable iff (srst)
		(setup_phase && is_status(paddr)) |=> prdata[14:0] == $past(flags);
	endproperty
	a_mirror: assert property (p_mirror) else $error("status views differ");

	property p_set_wins;
		@(posedge clk) disable iff (srst)
		(wr_status && pwdata[flag_bank_pkg::GP_TIMER_BIT] && gp_timer_timeout && !soft_rst)
			|=> flags[flag_bank_pkg::GP_TIMER_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat event");

	c_fatal: cover property (@(posedge clk) disable iff (srst) bus_fault ##[1:20] soft_rst);
	c_rx_cycle: cover property (@(posedge clk) disable iff (srst)
		rx_desc_not_owned ##[1:20] rx_poll);
	c_irq: cover property (@(posedge clk) disable iff (srst) $rose(irq));
	c_collide: cover property (@(posedge clk) disable iff (srst)
		wr_status && pwdata[flag_bank_pkg::GP_TIMER_BIT] && gp_timer_timeout);
endmodule : mac_dma_status_flag_latches

/* File: logic/sticky_flag.sv */
`timescale 1ns/1ps
// one high-latching flag, cleared by a write of one; a set wins over the clear
module sticky_flag (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// event and clear
	input wire logic set,
	input wire logic clr,
	// flag
	output logic q
);
	// latch on event, release on reset or on clear without event
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end
endmodule : sticky_flag

/* File: pkg/flag_bank_pkg.sv */
package flag_bank_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] CTRL_ADDR = 12'h000;
	localparam logic [11:0] PRIMARY_STATUS_ADDR = 12'h028;
	localparam logic [11:0] AUX_STATUS_ADDR = 12'h080;
	localparam logic [11:0] IRQ_MASK_ADDR = 12'h084;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FATAL_BIT = 13;
	localparam int GP_TIMER_BIT = 11;
	localparam int RX_WATCHDOG_BIT = 9;
	localparam int RX_HALTED_BIT = 8;
	localparam int RX_STARVED_BIT = 7;
	localparam int RX_DONE_BIT = 6;
	localparam int TX_UNDERRUN_BIT = 5;
	localparam int TX_JABBER_BIT = 3;
	localparam int FLAG_LO = 3;
	localparam int FLAG_HI = 13;
	localparam int MIRROR_HI = 14;
	localparam int PARITY_ERR_BIT = 23;
	localparam int MASTER_ABORT_BIT = 24;
	localparam int TARGET_ABORT_BIT = 25;
	localparam int CTRL_SOFT_RESET_BIT = 0;
	localparam int CTRL_RX_POLL_BIT = 1;
	localparam int CTRL_TX_POLL_BIT = 2;
	localparam int DESC_UNDERRUN_BIT = 1;
	localparam int DESC_JABBER_BIT = 14;

	// implemented flag positions; reserved ones read zero
	localparam logic [14:0] FLAG_IMPL = 15'h2BE8;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// process states, gray coded along the usual path
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RX_RUN = 2'b00,
		RX_SUSPENDED = 2'b01
	} rx_state_t;

	typedef enum logic [1:0] {
		TX_RUN = 2'b00,
		TX_SUSPENDED = 2'b01,
		TX_STOPPED = 2'b11
	} tx_state_t;
endpackage : flag_bank_pkg

/* File: test/host_apb_model.sv */
`timescale 1ns/1ps
// apb master standing in for host software
module host_apb_model (
	// clock
	input wire logic clk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// one transfer: setup, access held until pready, late set if it never comes
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic late);
		int n;
		late = 1'b1;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				late = 1'b0;
				break;
			end
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // released lines stop showing the last value
		pwdata <= ~d;
	endtask : xfer
endmodule : host_apb_model

/* File: test/mac_dma_status_flag_latches_tb.sv */
`timescale 1ns/1ps
module mac_dma_status_flag_latches_tb;
	localparam logic [11:0] CTRL = flag_bank_pkg::CTRL_ADDR;
	localparam logic [11:0] PRI = flag_bank_pkg::PRIMARY_STATUS_ADDR;
	localparam logic [11:0] AUX = flag_bank_pkg::AUX_STATUS_ADDR;
	localparam logic [11:0] MSK = flag_bank_pkg::IRQ_MASK_ADDR;
	// flag position of each event input index
	function automatic int flag_pos(input int k);
		case (k)
			1: flag_pos = flag_bank_pkg::GP_TIMER_BIT;
			2: flag_pos = flag_bank_pkg::RX_WATCHDOG_BIT;
			3: flag_pos = flag_bank_pkg::RX_HALTED_BIT;
			4: flag_pos = flag_bank_pkg::RX_STARVED_BIT;
			5: flag_pos = flag_bank_pkg::RX_DONE_BIT;
			6: flag_pos = flag_bank_pkg::TX_UNDERRUN_BIT;
			7: flag_pos = flag_bank_pkg::TX_JABBER_BIT;
			default: flag_pos = flag_bank_pkg::FATAL_BIT;
		endcase
	endfunction : flag_pos
	logic clk, srst, psel, penable, pwrite, pready, pslverr, rx_recog, irq;
	logic bus_en, rx_susp, tx_susp, tx_stop, desc_wr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, desc;
	logic [9:0] ev;
	int fail_count = 0;
	int check_count = 0;

	// clock and stimulus at time zero
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		srst = 1'b1;
		ev = 10'h000;
		rx_recog = 1'b0;
	end

	host_apb_model HOST (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	mac_dma_status_flag_latches DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .parity_error(ev[0]), .master_abort(ev[8]), .target_abort(ev[9]),
		.gp_timer_timeout(ev[1]), .rx_watchdog_timeout(ev[2]), .rx_state_stopped(ev[3]),
		.rx_desc_not_owned(ev[4]), .rx_frame_recognized(rx_recog), .rx_frame_complete(ev[5]),
		.tx_fifo_empty_in_frame(ev[6]), .tx_jabber_timeout(ev[7]), .bus_access_enable(bus_en),
		.rx_suspended(rx_susp), .tx_suspended(tx_susp), .tx_stopped(tx_stop),
		.tx_desc_status_wr(desc_wr), .tx_descriptor_status_word(desc), .irq(irq));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask : check

	// bus access; reads compare data, every access compares the error answer
	task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic eerr);
		logic [31:0] q;
		logic err, late;
		HOST.xfer(wr, a, d, q, err, late);
		if (late !== 1'b0) begin
			fail_count++;
			close_out();
		end
		if (!wr)
			check(q, exp, "read data");
		check({31'h0, err}, {31'h0, eerr}, "slave error");
	endtask : acc

	task automatic pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev[k] <= 1'b0;
		#1;
	endtask : pulse

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check({27'h0, bus_en, irq, rx_susp, tx_susp, tx_stop}, 32'h10, "reset outputs");
		acc(1'b0, AUX, 32'h0, 32'h0, 1'b0);
		acc(1'b0, MSK, 32'h0, 32'h0, 1'b0);
		acc(1'b0, 12'h0F0, 32'h0, 32'h0, 1'b1);
		acc(1'b1, 12'h0F4, 32'hFFFF_FFFF, 32'h0, 1'b1);
	endtask : t_reset

	task automatic t_flags();
		logic [31:0] e;
		for (int k = 1; k < 8; k++) begin
			e = 32'h1 << flag_pos(k);
			pulse(k);
			repeat (2) @(posedge clk);
			acc(1'b0, AUX, 32'h0, e, 1'b0);
			acc(1'b0, PRI, 32'h0, e, 1'b0);
			acc(1'b1, AUX, ~e, 32'h0, 1'b0);
			acc(1'b0, AUX, 32'h0, e, 1'b0);
			acc(1'b1, PRI, e, 32'h0, 1'b0);
			acc(1'b0, AUX, 32'h0, 32'h0, 1'b0);
		end
		acc(1'b1, CTRL, 32'h6, 32'h0, 1'b0);
	endtask : t_flags

	task automatic t_set_wins();
		pulse(1);
		fork
			acc(1'b1, AUX, 32'h800, 32'h0, 1'b0);
			begin
				repeat (2) @(posedge clk);
				ev[1] <= 1'b1;
				@(posedge clk);
				ev[1] <= 1'b0;
			end
		join
		acc(1'b1, PRI, 32'hFFFF_8000, 32'h0, 1'b0);
		acc(1'b0, AUX, 32'h0, 32'h800, 1'b0);
		acc(1'b1, AUX, 32'h800, 32'h0, 1'b0);
	endtask : t_set_wins

	task automatic t_irq();
		acc(1'b1, MSK, 32'h800, 32'h0, 1'b0);
		acc(1'b0, MSK, 32'h0, 32'h800, 1'b0);
		pulse(2);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0, "masked event irq");
		pulse(1);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h1, "irq raised");
		acc(1'b1, AUX, 32'hA00, 32'h0, 1'b0);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0, "irq cleared");
		acc(1'b1, MSK, 32'h0, 32'h0, 1'b0);
	endtask : t_irq

	task automatic t_rx();
		pulse(4);
		check({31'h0, rx_susp}, 32'h1, "rx suspended");
		acc(1'b1, CTRL, 32'h2, 32'h0, 1'b0);
		@(posedge clk);
		#1 check({31'h0, rx_susp}, 32'h0, "poll resumes");
		pulse(4);
		@(posedge clk);
		rx_recog <= 1'b1;
		@(posedge clk);
		rx_recog <= 1'b0;
		@(posedge clk);
		#1 check({31'h0, rx_susp}, 32'h0, "frame resumes");
	endtask : t_rx

	task automatic t_tx();
		pulse(6);
		check({29'h0, tx_susp, tx_stop, desc_wr}, 32'h5, "underrun state");
		check(desc, 32'h2, "underrun word");
		@(posedge clk);
		#1 check({31'h0, desc_wr}, 32'h0, "word write pulse");
		acc(1'b1, CTRL, 32'h4, 32'h0, 1'b0);
		@(posedge clk);
		pulse(7);
		check({29'h0, tx_susp, tx_stop, desc_wr}, 32'h3, "jabber state");
		check(desc, 32'h4000, "jabber word");
		acc(1'b1, AUX, 32'hFFFF_FFFF, 32'h0, 1'b0);
		acc(1'b0, AUX, 32'h0, 32'h0, 1'b0);
	endtask : t_tx

	task automatic t_fatal();
		int src;
		for (int i = 0; i < 3; i++) begin
			src = (i == 0) ? 0 : i + 7;
			pulse(src);
			check({31'h0, bus_en}, 32'h0, "access blocked");
			acc(1'b0, PRI, 32'h0, 32'h2000 | (32'h80_0000 << i), 1'b0);
			acc(1'b1, PRI, 32'h2000, 32'h0, 1'b0);
			check({31'h0, bus_en}, 32'h0, "clear keeps block");
			acc(1'b1, CTRL, 32'h1, 32'h0, 1'b0);
			@(posedge clk);
			#1 check({31'h0, bus_en}, 32'h1, "soft reset resumes");
			acc(1'b0, PRI, 32'h0, 32'h0, 1'b0);
		end
	endtask : t_fatal

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1 t_reset();
		t_flags();
		t_set_wins();
		t_irq();
		t_rx();
		t_tx();
		t_fatal();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule : mac_dma_status_flag_latches_tb
